// file: verilog/cmc_regs.svh
// Register map, field positions, reset values and counts of the CAN mode/interrupt block
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CMC_ADDR_CTRL1  3'h0
`define CMC_ADDR_CTRL2  3'h1
`define CMC_ADDR_VEC    3'h2
`define CMC_ADDR_FCTRL  3'h3
`define CMC_ADDR_FIFO   3'h4
`define CMC_ADDR_INTF   3'h5
`define CMC_ADDR_INTE   3'h6

// ----------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------
`define CMC_C1_SIDL     13
`define CMC_C1_ABORT    12
`define CMC_C1_CKS      11
`define CMC_C1_CAP      3
`define CMC_C1_WIN      0
`define CMC_FL_IVR      7
`define CMC_FL_WAK      6
`define CMC_FL_ERR      5
`define CMC_FL_FIFO     3
`define CMC_FL_OVF      2
`define CMC_FL_RB       1
`define CMC_FL_TB       0
`define CMC_FLAG_MASK   8'hEF
`define CMC_MODE_RST    3'h4
`define CMC_IC_NONE     7'h40
`define CMC_IC_ERR      7'h41
`define CMC_IC_WAKE     7'h42
`define CMC_IC_OVF      7'h43
`define CMC_IC_FIFO     7'h44
`define CMC_DN_MAX      5'h11
`define CMC_IDLE_BITS   11

`endif

// file: verilog/cmc_pkg.sv
// Types shared by the CAN mode/interrupt block
package cmc_pkg;

  // Operating modes, same code for request and status
  typedef enum logic [2:0] {
    CMC_NORMAL     = 3'h0,
    CMC_DISABLE    = 3'h1,
    CMC_LOOPBACK   = 3'h2,
    CMC_LISTEN     = 3'h3,
    CMC_CONFIG     = 3'h4,
    CMC_RSV5       = 3'h5,
    CMC_RSV6       = 3'h6,
    CMC_LISTEN_ALL = 3'h7
  } cmc_mode_e;

  // Error states from the protocol engine
  typedef struct packed {
    logic tx_bus_off;
    logic tx_bus_passive;
    logic rx_bus_passive;
    logic tx_warning;
    logic rx_warning;
  } cmc_err_s;

  // One-cycle events from the protocol engine
  typedef struct packed {
    logic       invalid_msg;
    logic       wakeup;
    logic       fifo_almost_full;
    logic       rx_overflow;
    logic       rx_buffer;
    logic       tx_buffer;
    logic [3:0] rx_buf_num;
    logic [2:0] tx_buf_num;
    logic [3:0] filter_hit;
  } cmc_evt_s;

endpackage

// file: verilog/cmc_mode_irq_ctrl.sv
// Mode sequencing, FIFO pointers and interrupt status of the CAN controller
`timescale 1ns/1ps
`include "cmc_regs.svh"

module cmc_mode_irq_ctrl
  import cmc_pkg::*;
#(
  parameter int IDLE_BITS = `CMC_IDLE_BITS
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        bit_strobe,
  input  wire logic        rx_bit,
  input  wire logic        chip_idle,
  input  wire logic        tx_abort_done,
  input  wire logic        msg_received,
  input  wire logic [4:0]  dn_count_in,
  input  wire cmc_err_s    err_state,
  input  wire cmc_evt_s    evt,
  input  wire logic        fifo_write,
  input  wire logic        fifo_read,
  output cmc_mode_e        mode_status,
  output logic             module_run,
  output logic             abort_all_tx,
  output logic             module_clock_double,
  output logic             capture_event,
  output logic             register_window_select,
  output logic      [4:0]  data_bit_filter_count,
  output logic      [5:0]  buffer_count,
  output logic      [5:0]  fifo_buffer_pointer,
  output logic      [5:0]  fifo_next_read_pointer,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Buffer count from the area size code
  function automatic logic [5:0] area_count(input logic [2:0] code);
    case (code)
      3'h0:    area_count = 6'h04;
      3'h1:    area_count = 6'h06;
      3'h2:    area_count = 6'h08;
      3'h3:    area_count = 6'h0C;
      3'h4:    area_count = 6'h10;
      3'h5:    area_count = 6'h18;
      default: area_count = 6'h20;  // Reserved code kept at largest
    endcase
  endfunction

  // Step a FIFO pointer, wrapping back to the start buffer
  function automatic logic [5:0] fifo_step(input logic [5:0] p,
                                           input logic [4:0] start,
                                           input logic [5:0] cnt);
    if (p + 6'h01 >= cnt) begin
      fifo_step = {1'b0, start};
    end else begin
      fifo_step = p + 6'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        stop_reg,    stop_next;
  logic        abort_reg,   abort_next;
  logic        cks_reg,     cks_next;
  logic [2:0]  req_reg,     req_next;
  cmc_mode_e   mode_reg,    mode_next;
  logic        cap_reg,     cap_next;
  logic        win_reg,     win_next;
  logic [3:0]  idle_reg,    idle_next;
  logic        run_reg,     run_next;
  logic        capev_reg,   capev_next;
  logic [4:0]  dn_reg,      dn_next;
  logic [2:0]  size_reg,    size_next;
  logic [4:0]  fsa_reg,     fsa_next;
  logic [5:0]  fbp_reg,     fbp_next;
  logic [5:0]  fifo_next_read_pointer_reg,    fifo_next_read_pointer_next;
  logic [5:0]  cnt_reg,     cnt_next;
  logic [7:0]  flag_reg,    flag_next;
  logic [7:0]  en_reg,      en_next;
  cmc_err_s    err_reg,     err_next;
  logic [6:0]  interrupt_code_reg,   interrupt_code_next;
  logic [4:0]  hit_reg,     hit_next;
  logic [3:0]  rxn_reg,     rxn_next;
  logic [2:0]  txn_reg,     txn_next;
  logic        irq_reg,     irq_next;
  logic [15:0] rdata_reg,   rdata_next;

  logic        wr_c1;
  logic        wr_fc;
  logic        wr_fl;
  logic        wr_en;
  logic        bus_idle;
  logic        req_ok;
  logic [7:0]  setv;
  logic [7:0]  pend;

  // Write decode
  assign wr_c1 = reg_wr && (reg_addr == `CMC_ADDR_CTRL1);
  assign wr_fc = reg_wr && (reg_addr == `CMC_ADDR_FCTRL);
  assign wr_fl = reg_wr && (reg_addr == `CMC_ADDR_INTF);
  assign wr_en = reg_wr && (reg_addr == `CMC_ADDR_INTE);

  // Bus idle once enough recessive bits are counted
  assign bus_idle = (idle_reg == 4'(IDLE_BITS));
  assign req_ok   = (req_reg != 3'h5) && (req_reg != 3'h6);

  // ----------------------------------------------------------------
  // Control and mode sequencing
  // ----------------------------------------------------------------

  // Next values of the control group
  always_comb begin
    stop_next  = stop_reg;
    abort_next = abort_reg;
    cks_next   = cks_reg;
    req_next   = req_reg;
    cap_next   = cap_reg;
    win_next   = win_reg;
    mode_next  = mode_reg;
    idle_next  = idle_reg;
    if (wr_c1) begin
      stop_next = reg_wdata[`CMC_C1_SIDL];
      cks_next  = reg_wdata[`CMC_C1_CKS];
      req_next  = reg_wdata[10:8];
      cap_next  = reg_wdata[`CMC_C1_CAP];
      win_next  = reg_wdata[`CMC_C1_WIN];
    end
    // Hardware clear on completion; a new set wins
    if (tx_abort_done) begin
      abort_next = 1'b0;
    end
    if (wr_c1 && reg_wdata[`CMC_C1_ABORT]) begin
      abort_next = 1'b1;
    end
    // Count consecutive recessive bits, saturating
    if (bit_strobe) begin
      if (!rx_bit) begin
        idle_next = 4'h0;
      end else if (!bus_idle) begin
        idle_next = idle_reg + 4'h1;
      end
    end
    // Switch mode only on an idle bus with a legal request
    if (bus_idle && req_ok && run_reg) begin
      mode_next = cmc_mode_e'(req_reg);
    end
    run_next   = !(stop_reg && chip_idle);
    capev_next = cap_reg && msg_received && run_reg;
  end

  // Control registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stop_reg  <= 1'b0;
      abort_reg <= 1'b0;
      cks_reg   <= 1'b0;
      req_reg   <= `CMC_MODE_RST;
      mode_reg  <= CMC_CONFIG;
      cap_reg   <= 1'b0;
      win_reg   <= 1'b0;
      idle_reg  <= 4'h0;
      run_reg   <= 1'b1;
      capev_reg <= 1'b0;
    end else begin
      stop_reg  <= stop_next;
      abort_reg <= abort_next;
      cks_reg   <= cks_next;
      req_reg   <= req_next;
      mode_reg  <= mode_next;
      cap_reg   <= cap_next;
      win_reg   <= win_next;
      idle_reg  <= idle_next;
      run_reg   <= run_next;
      capev_reg <= capev_next;
    end
  end

  // ----------------------------------------------------------------
  // FIFO area and pointers
  // ----------------------------------------------------------------

  // Next values of the FIFO group
  always_comb begin
    size_next = size_reg;
    fsa_next  = fsa_reg;
    fbp_next  = fbp_reg;
    fifo_next_read_pointer_next = fifo_next_read_pointer_reg;
    dn_next   = (dn_count_in > `CMC_DN_MAX) ? 5'h00 : dn_count_in;
    if (wr_fc) begin
      size_next = reg_wdata[15:13];
      fsa_next  = reg_wdata[4:0];
      fbp_next  = {1'b0, reg_wdata[4:0]};
      fifo_next_read_pointer_next = {1'b0, reg_wdata[4:0]};
    end else if (run_reg) begin
      if (fifo_write) begin
        fbp_next = fifo_step(fbp_reg, fsa_reg, cnt_reg);
      end
      if (fifo_read) begin
        fifo_next_read_pointer_next = fifo_step(fifo_next_read_pointer_reg, fsa_reg, cnt_reg);
      end
    end
    cnt_next = area_count(size_next);
  end

  // FIFO registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      size_reg <= 3'h0;
      fsa_reg  <= 5'h00;
      fbp_reg  <= 6'h00;
      fifo_next_read_pointer_reg <= 6'h00;
      cnt_reg  <= 6'h04;
      dn_reg   <= 5'h00;
    end else begin
      size_reg <= size_next;
      fsa_reg  <= fsa_next;
      fbp_reg  <= fbp_next;
      fifo_next_read_pointer_reg <= fifo_next_read_pointer_next;
      cnt_reg  <= cnt_next;
      dn_reg   <= dn_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags, enables and code
  // ----------------------------------------------------------------

  // Events that set flags while the module runs
  always_comb begin
    setv = 8'h00;
    setv[`CMC_FL_IVR]  = evt.invalid_msg;
    setv[`CMC_FL_WAK]  = evt.wakeup;
    setv[`CMC_FL_ERR]  = |(err_state & ~err_reg);
    setv[`CMC_FL_FIFO] = evt.fifo_almost_full;
    setv[`CMC_FL_OVF]  = evt.rx_overflow;
    setv[`CMC_FL_RB]   = evt.rx_buffer;
    setv[`CMC_FL_TB]   = evt.tx_buffer;
    setv = setv & {8{run_reg}};
  end

  // Next values of the interrupt group
  always_comb begin
    flag_next = flag_reg;
    en_next   = en_reg;
    hit_next  = hit_reg;
    rxn_next  = rxn_reg;
    txn_next  = txn_reg;
    err_next  = err_state;
    if (wr_fl) begin
      flag_next = flag_reg & reg_wdata[7:0];
    end
    flag_next = (flag_next | setv) & `CMC_FLAG_MASK;
    if (wr_en) begin
      en_next = reg_wdata[7:0] & `CMC_FLAG_MASK;
    end
    if (setv[`CMC_FL_RB]) begin
      rxn_next = evt.rx_buf_num;
      hit_next = {1'b0, evt.filter_hit};
    end
    if (setv[`CMC_FL_TB]) begin
      txn_next = evt.tx_buf_num;
    end
    pend     = flag_next & en_next;
    irq_next = |pend;
    // Fixed priority among pending sources
    if (pend[`CMC_FL_ERR]) begin
      interrupt_code_next = `CMC_IC_ERR;
    end else if (pend[`CMC_FL_OVF]) begin
      interrupt_code_next = `CMC_IC_OVF;
    end else if (pend[`CMC_FL_WAK]) begin
      interrupt_code_next = `CMC_IC_WAKE;
    end else if (pend[`CMC_FL_FIFO]) begin
      interrupt_code_next = `CMC_IC_FIFO;
    end else if (pend[`CMC_FL_RB]) begin
      interrupt_code_next = {3'h0, rxn_next};
    end else if (pend[`CMC_FL_TB]) begin
      interrupt_code_next = {4'h0, txn_next};
    end else begin
      interrupt_code_next = `CMC_IC_NONE;
    end
  end

  // Interrupt registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_reg  <= 8'h00;
      en_reg    <= 8'h00;
      err_reg   <= '0;
      interrupt_code_reg <= `CMC_IC_NONE;
      hit_reg   <= 5'h00;
      rxn_reg   <= 4'h0;
      txn_reg   <= 3'h0;
      irq_reg   <= 1'b0;
    end else begin
      flag_reg  <= flag_next;
      en_reg    <= en_next;
      err_reg   <= err_next;
      interrupt_code_reg <= interrupt_code_next;
      hit_reg   <= hit_next;
      rxn_reg   <= rxn_next;
      txn_reg   <= txn_next;
      irq_reg   <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `CMC_ADDR_CTRL1: rdata_next = {2'h0, stop_reg, abort_reg, cks_reg,
                                       req_reg, mode_reg, 1'b0, cap_reg,
                                       2'h0, win_reg};
        `CMC_ADDR_CTRL2: rdata_next = {11'h000, dn_reg};
        `CMC_ADDR_VEC:   rdata_next = {3'h0, hit_reg, 1'b0, interrupt_code_reg};
        `CMC_ADDR_FCTRL: rdata_next = {size_reg, 8'h00, fsa_reg};
        `CMC_ADDR_FIFO:  rdata_next = {2'h0, fbp_reg, 2'h0, fifo_next_read_pointer_reg};
        `CMC_ADDR_INTF:  rdata_next = {2'h0, err_reg,
                                       err_reg.tx_warning | err_reg.rx_warning,
                                       flag_reg};
        `CMC_ADDR_INTE:  rdata_next = {8'h00, en_reg};
        default:         rdata_next = 16'h0000;
      endcase
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata              = rdata_reg;
  assign mode_status            = mode_reg;
  assign module_run             = run_reg;
  assign abort_all_tx           = abort_reg;
  assign module_clock_double    = cks_reg;
  assign capture_event          = capev_reg;
  assign register_window_select = win_reg;
  assign data_bit_filter_count  = dn_reg;
  assign buffer_count           = cnt_reg;
  assign fifo_buffer_pointer    = fbp_reg;
  assign fifo_next_read_pointer = fifo_next_read_pointer_reg;
  assign irq                    = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_MODE_WAITS_IDLE: assert property (
    $changed(mode_reg) |-> $past(bus_idle))
    else $error("mode changed without idle bus");

  AST_MODE_FOLLOWS: assert property (
    bus_idle && req_ok && run_reg && !wr_c1 |=> mode_reg == $past(req_reg))
    else $error("legal request not taken on idle bus");

  AST_MODE_NO_RSV: assert property (
    mode_reg != CMC_RSV5 && mode_reg != CMC_RSV6)
    else $error("reserved mode entered");

  AST_STOP_IDLE: assert property (
    stop_reg && chip_idle |=> !run_reg ##1 mode_reg == $past(mode_reg))
    else $error("module ran in idle with stop set");

  AST_ABORT_CLEAR: assert property (
    abort_reg && tx_abort_done && !wr_c1 |=> !abort_reg)
    else $error("abort not cleared when done");

  AST_CAPTURE: assert property (
    run_reg && msg_received |=> capture_event == $past(cap_reg))
    else $error("capture event wrong");

  AST_RB_SET_WINS: assert property (
    run_reg && evt.rx_buffer |=> flag_reg[`CMC_FL_RB])
    else $error("rx buffer flag lost");

  AST_FLAG_CLEAR: assert property (
    wr_fl && !reg_wdata[`CMC_FL_TB] && !(run_reg && evt.tx_buffer)
    |=> !flag_reg[`CMC_FL_TB])
    else $error("tx buffer flag not cleared by zero");

  AST_ERR_RISE: assert property (
    run_reg && |(err_state & ~err_reg) |=> flag_reg[`CMC_FL_ERR])
    else $error("error flag not set on new error state");

  AST_IRQ_GATE: assert property (
    irq_reg == |(flag_reg & en_reg))
    else $error("interrupt request not gated by enables");

  AST_INTERRUPT_CODE_NONE: assert property (
    !irq_reg |-> interrupt_code_reg == `CMC_IC_NONE)
    else $error("code shown with nothing pending");

  AST_FBP_RANGE: assert property (
    fifo_write && run_reg && !wr_fc && fbp_reg + 6'h01 >= cnt_reg
    |=> fbp_reg == {1'b0, fsa_reg})
    else $error("fifo pointer did not wrap");

  COV_MODE_SWITCH: cover property ($changed(mode_reg));
  COV_ABORT_DONE:  cover property ($fell(abort_reg));
  COV_IRQ_RISE:    cover property ($rose(irq_reg));
  COV_FBP_WRAP:    cover property (fifo_write ##1 fbp_reg == {1'b0, fsa_reg});

endmodule // cmc_mode_irq_ctrl

// file: verif/cmc_bus_model.sv
// Bus-side model: another node sending CAN bits, one per four clocks
`timescale 1ns/1ps

module cmc_bus_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       frame_on,
  input  wire logic       dominant,
  output logic            bit_strobe,
  output logic            rx_bit,
  output logic [7:0]      bit_count
);

  logic [1:0] div_reg;

  // Bit pacing; between strobes the line toggles every clock, inverting its last level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg    <= 2'h0;
      bit_strobe <= 1'b0;
      rx_bit     <= 1'b1;
      bit_count  <= 8'h00;
    end else if (frame_on) begin
      div_reg    <= div_reg + 2'h1;
      bit_strobe <= (div_reg == 2'h3);
      rx_bit     <= (div_reg == 2'h3) ? !dominant : !rx_bit;
      bit_count  <= bit_count + {7'h00, div_reg == 2'h3};
    end else begin
      div_reg    <= 2'h0;
      bit_strobe <= 1'b0;
      rx_bit     <= 1'b1;
      bit_count  <= 8'h00;
    end
  end

endmodule // cmc_bus_model

// file: verif/testbench.sv
// Self-checking bench of the CAN mode and interrupt block
`timescale 1ns/1ps

module testbench
  import cmc_pkg::*;
;

  logic        core_clk;
  logic        rstn;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        bit_strobe;
  logic        rx_bit;
  logic        chip_idle;
  logic        tx_abort_done;
  logic        msg_received;
  logic [4:0]  dn_count_in;
  cmc_err_s    err_state;
  cmc_evt_s    evt;
  logic        fifo_write;
  logic        fifo_read;
  cmc_mode_e   mode_status;
  logic        module_run;
  logic        abort_all_tx;
  logic        module_clock_double;
  logic        capture_event;
  logic        register_window_select;
  logic [4:0]  data_bit_filter_count;
  logic [5:0]  buffer_count;
  logic [5:0]  fifo_buffer_pointer;
  logic [5:0]  fifo_next_read_pointer;
  logic        irq;
  logic        frame_on;
  logic        dominant;
  logic [7:0]  bit_count;
  int          errors;
  int          n_checks;

  cmc_mode_irq_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_strobe(bit_strobe), .rx_bit(rx_bit), .chip_idle(chip_idle),
    .tx_abort_done(tx_abort_done), .msg_received(msg_received), .dn_count_in(dn_count_in),
    .err_state(err_state), .evt(evt), .fifo_write(fifo_write), .fifo_read(fifo_read),
    .mode_status(mode_status), .module_run(module_run), .abort_all_tx(abort_all_tx),
    .module_clock_double(module_clock_double), .capture_event(capture_event),
    .register_window_select(register_window_select),
    .data_bit_filter_count(data_bit_filter_count), .buffer_count(buffer_count),
    .fifo_buffer_pointer(fifo_buffer_pointer),
    .fifo_next_read_pointer(fifo_next_read_pointer), .irq(irq));

  cmc_bus_model u_bus (.core_clk(core_clk), .rstn(rstn), .frame_on(frame_on),
    .dominant(dominant), .bit_strobe(bit_strobe), .rx_bit(rx_bit), .bit_count(bit_count));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, e);
  endtask

  task automatic send(input int n, input logic dom);
    @(posedge core_clk);
    frame_on <= 1'b1;
    dominant <= dom;
    for (int k = 0; k < 400 && bit_count != 8'(n); k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("bits sent", 16'(bit_count), 16'(n));
    @(posedge core_clk);
    frame_on <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse_evt(input cmc_evt_s v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= '0;
    #1;
  endtask

  task automatic cap_pulse(input logic e);
    @(posedge core_clk);
    msg_received <= 1'b1;
    @(posedge core_clk);
    msg_received <= 1'b0;
    #1;
    chk("capture", 16'(capture_event), 16'(e));
    @(posedge core_clk);
    #1;
    chk("capture end", 16'(capture_event), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("mode rst", 16'(mode_status), 16'h0004);
    chk("bufcnt rst", 16'(buffer_count), 16'h0004);
    rd(3'h0, 16'h0480, "ctrl1 rst");
    rd(3'h2, 16'h0040, "code rst");
    rd(3'h7, 16'h0000, "unmapped");
    @(posedge core_clk);
    #1;
    chk("rdata idle", reg_rdata, 16'h0000);
  endtask

  task automatic t_mode;
    logic [2:0] st;
    logic [2:0] c;
    st = 3'h4;
    wr(3'h0, 16'h0809);
    send(10, 1'b0);
    chk("mode 10 bits", 16'(mode_status), 16'h0004);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(3'h0, 16'h0809 | {5'h00, c, 8'h00});
      send(1, 1'b1);
      send(11, 1'b0);
      if (c != 3'h5 && c != 3'h6) st = c;
      chk("mode", 16'(mode_status), 16'(st));
      rd(3'h0, 16'h0809 | {5'h00, c, st, 5'h00}, "ctrl1 mode");
    end
  endtask

  task automatic t_ctrl;
    cmc_evt_s v;
    v = '0;
    v.rx_buffer = 1'b1;
    wr(3'h0, 16'h2F09);
    chk("clk2x", 16'(module_clock_double), 16'h0001);
    chk("window", 16'(register_window_select), 16'h0001);
    @(posedge core_clk);
    chip_idle <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("halted", 16'(module_run), 16'h0000);
    pulse_evt(v);
    rd(3'h5, 16'h0000, "flags halted");
    wr(3'h0, 16'h0F09);
    @(posedge core_clk);
    #1;
    chk("idle run", 16'(module_run), 16'h0001);
    @(posedge core_clk);
    chip_idle <= 1'b0;
    wr(3'h0, 16'h1F09);
    chk("abort set", 16'(abort_all_tx), 16'h0001);
    wr(3'h0, 16'h0F09);
    chk("abort held", 16'(abort_all_tx), 16'h0001);
    @(posedge core_clk);
    tx_abort_done <= 1'b1;
    @(posedge core_clk);
    tx_abort_done <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("abort clr", 16'(abort_all_tx), 16'h0000);
    rd(3'h0, 16'h0FE9, "ctrl1");
    cap_pulse(1'b1);
    wr(3'h0, 16'h0700);
    chk("clk1x", 16'(module_clock_double), 16'h0000);
    chk("buf window", 16'(register_window_select), 16'h0000);
    cap_pulse(1'b0);
  endtask

  task automatic t_dn;
    logic [4:0] vi [4] = '{5'h11, 5'h12, 5'h01, 5'h1F};
    logic [4:0] ve [4] = '{5'h11, 5'h00, 5'h01, 5'h00};
    wr(3'h1, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      dn_count_in <= vi[i];
      @(posedge core_clk);
      @(posedge core_clk);
      #1;
      chk("dncount", 16'(data_bit_filter_count), 16'(ve[i]));
      rd(3'h1, 16'(ve[i]), "ctrl2");
    end
  endtask

  task automatic t_flags;
    logic [7:0] fm [6] = '{8'h02, 8'h80, 8'h40, 8'h08, 8'h04, 8'h01};
    logic [6:0] cd [6] = '{7'h0F, 7'h40, 7'h42, 7'h44, 7'h43, 7'h07};
    cmc_evt_s v;
    wr(3'h6, 16'hFFFF);
    rd(3'h6, 16'h00EF, "enables");
    for (int i = 0; i < 6; i++) begin
      v = '0;
      {v.invalid_msg, v.wakeup, v.fifo_almost_full} = {fm[i][7], fm[i][6], fm[i][3]};
      {v.rx_overflow, v.rx_buffer, v.tx_buffer} = fm[i][2:0];
      v.rx_buf_num = 4'hF;
      v.tx_buf_num = 3'h7;
      v.filter_hit = 4'hE;
      pulse_evt(v);
      rd(3'h5, 16'(fm[i]), "flag");
      rd(3'h2, 16'h0E00 | 16'(cd[i]), "code");
      chk("irq on", 16'(irq), 16'h0001);
      wr(3'h5, 16'h0000);
      rd(3'h5, 16'h0000, "flag clr");
      chk("irq off", 16'(irq), 16'h0000);
    end
    v = '0;
    v.rx_overflow = 1'b1;
    v.tx_buffer = 1'b1;
    v.tx_buf_num = 3'h3;
    pulse_evt(v);
    rd(3'h2, 16'h0E43, "prio");
    wr(3'h6, 16'h00EB);
    rd(3'h2, 16'h0E03, "prio masked");
    wr(3'h6, 16'h0000);
    rd(3'h2, 16'h0E40, "all masked");
    chk("irq masked", 16'(irq), 16'h0000);
    wr(3'h6, 16'h00EF);
    wr(3'h5, 16'h0000);
  endtask

  task automatic t_err;
    @(posedge core_clk);
    err_state <= 5'b00010;
    rd(3'h5, 16'h0520, "err flags");
    rd(3'h2, 16'h0E41, "err code");
    wr(3'h5, 16'h00FF);
    rd(3'h5, 16'h0520, "write one");
    wr(3'h5, 16'h0000);
    rd(3'h5, 16'h0500, "err clr");
    @(posedge core_clk);
    err_state <= 5'b10111;
    rd(3'h5, 16'h2F20, "err more");
  endtask

  task automatic t_fifo;
    logic [5:0] sz [8] = '{6'd4, 6'd6, 6'd8, 6'd12, 6'd16, 6'd24, 6'd32, 6'd32};
    for (int i = 0; i < 8; i++) begin
      wr(3'h3, {3'(i), 13'h0002});
      @(posedge core_clk);
      #1;
      chk("bufcnt", 16'(buffer_count), 16'(sz[i]));
    end
    wr(3'h3, 16'h0002);
    rd(3'h3, 16'h0002, "fctrl");
    rd(3'h4, 16'h0202, "fifo start");
    @(posedge core_clk);
    fifo_write <= 1'b1;
    @(posedge core_clk);
    fifo_write <= 1'b0;
    fifo_read  <= 1'b1;
    @(posedge core_clk);
    fifo_read <= 1'b0;
    rd(3'h4, 16'h0303, "fifo step");
    @(posedge core_clk);
    fifo_write <= 1'b1;
    @(posedge core_clk);
    fifo_write <= 1'b0;
    #1;
    chk("fbp wrap", 16'(fifo_buffer_pointer), 16'h0002);
    chk("fifo_next_read_pointer out", 16'(fifo_next_read_pointer), 16'h0003);
    wr(3'h3, 16'hFFFF);
    rd(3'h3, 16'hE01F, "fctrl full");
    wr(3'h4, 16'h0000);
    rd(3'h4, 16'h1F1F, "fifo top");
  endtask

  // ----------------------------------------------------------------
  // Clock, stimulus and watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = !core_clk;
  end

  // Watchdog well beyond the expected run time
  initial begin
    #(40 * 20000);
    errors++;
    end_of_test;
  end

  // Main sequence
  initial begin
    {rstn, reg_wr, reg_rd, chip_idle, tx_abort_done, msg_received} = '0;
    {fifo_write, fifo_read, frame_on, dominant} = '0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    dn_count_in = 5'h00;
    err_state = '0;
    evt = '0;
    errors = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset;
    t_mode;
    t_ctrl;
    t_dn;
    t_flags;
    t_err;
    t_fifo;
    end_of_test;
  end

endmodule // testbench
